//--- hw/spcm_core.sv
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
// APB-reached manager of protected page cache life-cycle state
module spcm_core
    import spcm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_busy
);
    spcm_state_e state_reg;
    logic [31:0] arg_reg;
    logic [3:0] op_reg;
    logic [2:0] stat_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic gen2_reg;
    logic [TAGW-1:0] tagi_reg;
    logic [TAGW-1:0] tago_reg;
    logic [7:0] evt_reg;
    logic [NPAGE-1:0] valid_reg, blocked_reg, pending_reg, tlb_reg, tracked_reg;
    logic [1:0] type_reg [NPAGE];
    logic [EW-1:0] owner_reg [NPAGE];
    logic [TAGW-1:0] data_reg [NPAGE];
    logic [VERW-1:0] ver_reg [NPAGE];
    logic [VERW-1:0] slot_reg [NPAGE][VSLOTS];
    logic [VERW-1:0] gver_reg;
    logic [NENC-1:0] ctl_res_reg;

    // Operand decode
    wire logic [PW-1:0] pg = arg_reg[F_PAGE +: PW];
    wire logic [EW-1:0] en = arg_reg[F_ENC +: EW];
    wire logic [PW-1:0] vp = arg_reg[F_VAPG +: PW];
    wire logic [SW-1:0] sl = arg_reg[F_SLOT +: SW];
    wire logic [EW-1:0] pg_owner = owner_reg[pg];
    wire logic [VERW-1:0] slot_ver = slot_reg[vp][sl];
    wire logic va_ok = valid_reg[vp] && type_reg[vp] == T_VA;
    wire logic ctl_here = ctl_res_reg[en];
    wire logic is_dyn = op_reg == OP_AUG || op_reg == OP_ACCEPT;
    wire logic [TAGW-1:0] tag_now;
    wire logic [TAGW-1:0] tag_evict;
    // A page reloads with the type it had when evicted: a control page only into an
    // enclave that lacks one, a regular page only once its control page is back, a VA page at any time
    wire logic ld_is_ctl = type_reg[pg] == T_CTL;
    wire logic ld_order_ok = ld_is_ctl ? !ctl_here : (type_reg[pg] == T_VA || ctl_here);

    // Count resident regular pages of the target page's own enclave; the recorded
    // owner is used so a wrong enclave operand cannot free a control page early
    logic [NPAGE-1:0] members;
    genvar gi;
    generate
        for (gi = 0; gi < NPAGE; gi++) begin : g_mem
            assign members[gi] = valid_reg[gi] && owner_reg[gi] == pg_owner
                && type_reg[gi] == T_REG;
        end
    endgenerate
    wire logic others_resident = |(members & ~(NPAGE'(1) << pg));

    spcm_tag u_tag (
        .i_page(pg),
        .i_enc(en),
        .i_ver(slot_ver),
        .i_data(data_reg[pg]),
        .o_tag(tag_now)
    );

    // Tag handed out on eviction is the one a later reload of this copy must present
    spcm_tag u_tag_evict (
        .i_page(pg),
        .i_enc(pg_owner),
        .i_ver(gver_reg),
        .i_data(data_reg[pg]),
        .o_tag(tag_evict)
    );

    // Precondition per operation; a false one changes no page state
    logic ok;
    logic [2:0] fail_code;
    always_comb begin
        ok = 1'b0;
        fail_code = S_FAIL;
        unique case (op_reg)
            OP_BLOCK: ok = valid_reg[pg] && type_reg[pg] == T_REG && !pending_reg[pg];
            OP_TRACK: ok = ctl_here;
            OP_EVICT: begin
                if (type_reg[pg] == T_CTL)
                    ok = valid_reg[pg] && !others_resident && va_ok;
                else if (type_reg[pg] == T_VA)
                    ok = valid_reg[pg] && vp != pg && va_ok;
                else
                    ok = valid_reg[pg] && blocked_reg[pg] && tracked_reg[pg]
                        && !tlb_reg[pg] && va_ok;
                ok = ok && slot_ver == '0;
            end
            OP_LDU, OP_LDB:
                ok = !valid_reg[pg] && va_ok && slot_ver != '0 && ld_order_ok
                    && tagi_reg == tag_now;
            OP_ADDVA, OP_ADDCTL: ok = !valid_reg[pg] && !(op_reg == OP_ADDCTL && ctl_here);
            OP_ADDREG: ok = !valid_reg[pg] && ctl_here;
            OP_AUG: ok = !valid_reg[pg] && ctl_here;
            OP_ACCEPT: ok = valid_reg[pg] && pending_reg[pg] && type_reg[pg] == T_REG
                && owner_reg[pg] == en;
            OP_ACCESS: begin
                // A cached translation keeps a blocked page usable until the flush
                ok = valid_reg[pg] && !pending_reg[pg] && (!blocked_reg[pg] || tlb_reg[pg]);
                fail_code = S_PF;
            end
            OP_IPI: ok = 1'b1;
            default: fail_code = S_BADOP;
        endcase
        if (is_dyn && !gen2_reg) begin
            ok = 1'b0;
            fail_code = S_NOSUP;
        end
    end

    // APB decode
    wire logic acc = i_psel && i_penable && pready_reg;
    wire logic wr = acc && i_pwrite;
    wire logic hit = i_paddr == A_CMD || i_paddr == A_ARG || i_paddr == A_STAT
        || i_paddr == A_PAGE || i_paddr == A_CFG || i_paddr == A_EVT
        || i_paddr == A_TAGI || i_paddr == A_TAGO;
    wire logic start = wr && i_paddr == A_CMD && state_reg == ST_IDLE;
    wire logic [PW-1:0] rpg = arg_reg[F_PAGE +: PW];
    wire logic [31:0] page_word = {8'h00, ver_reg[rpg], 6'h00, owner_reg[rpg],
        1'b0, type_reg[rpg], tracked_reg[rpg], tlb_reg[rpg], pending_reg[rpg],
        blocked_reg[rpg], valid_reg[rpg]};
    wire logic [31:0] rdata =
        i_paddr == A_CMD ? {28'h0, op_reg} :
        i_paddr == A_ARG ? arg_reg :
        i_paddr == A_STAT ? {28'h0, state_reg != ST_IDLE, stat_reg} :
        i_paddr == A_PAGE ? page_word :
        i_paddr == A_CFG ? {31'h0, gen2_reg} :
        i_paddr == A_EVT ? {24'h0, evt_reg} :
        i_paddr == A_TAGI ? {16'h0, tagi_reg} :
        i_paddr == A_TAGO ? {16'h0, tago_reg} : 32'h0;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end else begin
            // One wait state: ready rises in the second access cycle
            // Read data is caught in the wait state so that it stands with ready
            pready_reg <= i_psel && i_penable && !pready_reg;
            pslverr_reg <= i_psel && i_penable && !pready_reg && !hit;
            prdata_reg <= (i_psel && !i_pwrite) ? rdata : 32'h0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            arg_reg <= 32'h0;
            gen2_reg <= 1'b0;
            tagi_reg <= '0;
        end else if (wr && state_reg == ST_IDLE) begin
            // Operands freeze while an operation runs, so a late write cannot
            // retarget the page that is being changed
            if (i_paddr == A_ARG) arg_reg <= i_pwdata;
            if (i_paddr == A_CFG) gen2_reg <= i_pwdata[0];
            if (i_paddr == A_TAGI) tagi_reg <= i_pwdata[TAGW-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
            op_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (start) begin
                    op_reg <= i_pwdata[3:0];
                    state_reg <= ST_EXEC;
                end
                // EXEC decides and commits in one cycle; DONE holds busy one more
                // cycle so status is settled before software sees it clear
                ST_EXEC: state_reg <= ST_DONE;
                ST_DONE: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Page state updates, taken only in the execute cycle and only when ok
    wire logic go = state_reg == ST_EXEC && ok;
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            valid_reg <= '0;
            blocked_reg <= '0;
            pending_reg <= '0;
            tlb_reg <= '0;
            tracked_reg <= '0;
            ctl_res_reg <= '0;
            stat_reg <= STAT_RST;
            evt_reg <= 8'h00;
            tago_reg <= '0;
            gver_reg <= VER_RST;
            for (int p = 0; p < NPAGE; p++) begin
                type_reg[p] <= T_REG;
                owner_reg[p] <= '0;
                data_reg[p] <= '0;
                ver_reg[p] <= '0;
                for (int s = 0; s < VSLOTS; s++) slot_reg[p][s] <= '0;
            end
        end else if (state_reg == ST_EXEC) begin
            stat_reg <= ok ? S_OK : fail_code;
            evt_reg <= evt_reg + 8'h01;
            if (go) begin
                unique case (op_reg)
                    OP_BLOCK: begin
                        blocked_reg[pg] <= 1'b1;
                        tracked_reg[pg] <= 1'b0;
                    end
                    OP_TRACK: begin
                        // Marks blocked pages of this enclave as tracked
                        for (int p = 0; p < NPAGE; p++)
                            if (valid_reg[p] && blocked_reg[p] && owner_reg[p] == en)
                                tracked_reg[p] <= 1'b1;
                    end
                    OP_IPI: tlb_reg <= '0;
                    OP_EVICT: begin
                        valid_reg[pg] <= 1'b0;
                        tago_reg <= tag_evict;
                        slot_reg[vp][sl] <= gver_reg;
                        ver_reg[pg] <= gver_reg;
                        gver_reg <= gver_reg + VER_RST;
                        if (type_reg[pg] == T_CTL) ctl_res_reg[owner_reg[pg]] <= 1'b0;
                    end
                    OP_LDU, OP_LDB: begin
                        valid_reg[pg] <= 1'b1;
                        blocked_reg[pg] <= op_reg == OP_LDB;
                        tlb_reg[pg] <= 1'b0;
                        owner_reg[pg] <= en;
                        tracked_reg[pg] <= 1'b0;
                        // Type survives eviction, so a control page returns as one
                        if (ld_is_ctl) ctl_res_reg[en] <= 1'b1;
                        slot_reg[vp][sl] <= '0;
                    end
                    OP_ADDVA, OP_ADDCTL, OP_ADDREG, OP_AUG: begin
                        valid_reg[pg] <= 1'b1;
                        blocked_reg[pg] <= 1'b0;
                        tlb_reg[pg] <= 1'b0;
                        owner_reg[pg] <= en;
                        data_reg[pg] <= '0;
                        pending_reg[pg] <= op_reg == OP_AUG;
                        type_reg[pg] <= op_reg == OP_ADDVA ? T_VA :
                            op_reg == OP_ADDCTL ? T_CTL : T_REG;
                        if (op_reg == OP_ADDCTL) ctl_res_reg[en] <= 1'b1;
                        if (op_reg == OP_ADDVA)
                            for (int s = 0; s < VSLOTS; s++) slot_reg[pg][s] <= '0;
                    end
                    OP_ACCEPT: pending_reg[pg] <= 1'b0;
                    OP_ACCESS: begin
                        tlb_reg[pg] <= 1'b1;
                        data_reg[pg] <= data_reg[pg] + {8'h00, arg_reg[31:24]};
                    end
                    default: ;
                endcase
            end
        end
    end

    // Ready, error and read data leave straight from their flops; busy is high
    // exactly while the sequencer is away from idle

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    always_ff @(posedge i_clk) begin
        if (!i_rstn) o_busy <= 1'b0;
        else o_busy <= start || (state_reg == ST_EXEC);
    end
endmodule : spcm_core

//--- hw/spcm_pkg.sv
// Package with constants, types and register map for the page cache state manager
package spcm_pkg;
    localparam int NPAGE = 16;
    localparam int PW = 4;
    localparam int NENC = 4;
    localparam int EW = 2;
    localparam int VSLOTS = 8;
    localparam int SW = 3;
    localparam int VERW = 8;
    localparam int TAGW = 16;
    // Register byte offsets
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_ARG = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_PAGE = 8'h0C;
    localparam logic [7:0] A_CFG = 8'h10;
    localparam logic [7:0] A_EVT = 8'h14;
    localparam logic [7:0] A_TAGI = 8'h18;
    localparam logic [7:0] A_TAGO = 8'h1C;
    // Command codes
    localparam logic [3:0] OP_BLOCK = 4'h1;
    localparam logic [3:0] OP_TRACK = 4'h2;
    localparam logic [3:0] OP_EVICT = 4'h3;
    localparam logic [3:0] OP_LDU = 4'h4;
    localparam logic [3:0] OP_LDB = 4'h5;
    localparam logic [3:0] OP_ADDVA = 4'h6;
    localparam logic [3:0] OP_AUG = 4'h7;
    localparam logic [3:0] OP_ACCEPT = 4'h8;
    localparam logic [3:0] OP_ADDCTL = 4'h9;
    localparam logic [3:0] OP_ADDREG = 4'hA;
    localparam logic [3:0] OP_ACCESS = 4'hB;
    localparam logic [3:0] OP_IPI = 4'hC;
    // Page types
    localparam logic [1:0] T_REG = 2'h0;
    localparam logic [1:0] T_CTL = 2'h1;
    localparam logic [1:0] T_VA = 2'h2;
    // Status codes
    localparam logic [2:0] S_OK = 3'h0;
    localparam logic [2:0] S_FAIL = 3'h1;
    localparam logic [2:0] S_PF = 3'h2;
    localparam logic [2:0] S_NOSUP = 3'h3;
    localparam logic [2:0] S_BADOP = 3'h4;
    // Field positions in the argument register
    localparam int F_PAGE = 0;
    localparam int F_ENC = 4;
    localparam int F_VAPG = 8;
    localparam int F_SLOT = 12;
    localparam int F_TLB = 16;
    localparam logic [2:0] STAT_RST = 3'h0;
    localparam logic [VERW-1:0] VER_RST = 8'h01;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_DONE = 3'b100
    } spcm_state_e;
endpackage : spcm_pkg

//--- hw/spcm_tag.sv
`timescale 1ns/1ns
// Integrity tag function over page identity, version and contents digest
module spcm_tag
    import spcm_pkg::*;
(
    input wire logic [PW-1:0] i_page,
    input wire logic [EW-1:0] i_enc,
    input wire logic [VERW-1:0] i_ver,
    input wire logic [TAGW-1:0] i_data,
    output logic [TAGW-1:0] o_tag
);
    // Stand-in for the abstracted MAC engine; binds page, owner, version and data
    wire logic [TAGW-1:0] mix;
    assign mix = {i_ver, 2'h0, i_enc, i_page} ^ i_data;
    assign o_tag = {mix[10:0], mix[15:11]} ^ 16'hA5C3;
endmodule : spcm_tag

//--- test/spcm_host.sv
// APB master model standing in for system software
`timescale 1ns/1ns
module spcm_host (
    input wire logic i_clk,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (i_pready !== 1'b1);
        q = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // Released data must not look like the last value
        o_pwdata <= ~d;
    endtask : xfer
endmodule : spcm_host

//--- test/spcm_properties.sv
// Port-level checks on the page cache state manager
`timescale 1ns/1ns
module spcm_properties
    import spcm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_busy
);
    wire acc = i_psel && i_penable && o_pready;
    wire cmd_wr = acc && i_pwrite && i_paddr == A_CMD && !o_busy;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wait_state_a: assert property (i_psel && !i_penable |=> !o_pready ##1 o_pready)
        else $error("pready not after one wait state");
    ready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (o_pready |-> i_psel && i_penable)
        else $error("pready outside access phase");
    err_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (acc && i_paddr > A_TAGO |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && i_paddr[1:0] == 2'h0 && i_paddr <= A_TAGO |-> !o_pslverr)
        else $error("mapped access flagged as error");
    busy_start_a: assert property (cmd_wr |-> ##[1:3] o_busy)
        else $error("command did not start");
    busy_end_a: assert property ($rose(o_busy) |-> ##[1:4] !o_busy)
        else $error("operation did not finish");
    reset_quiet_a: assert property ($rose(i_rstn) |-> !o_pready && !o_busy && !o_pslverr)
        else $error("outputs active after reset");
endmodule : spcm_properties

bind spcm_core spcm_properties u_spcm_properties (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_busy(o_busy));

//--- test/testbench.sv
// Self-checking bench for the page cache state manager
`timescale 1ns/1ns
module testbench;
    import spcm_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, busy, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int errors = 0;
    int num_checks = 0;
    localparam logic [31:0] M = 32'h67;
    always #5 i_clk = ~i_clk;
    spcm_core u_spcm_core (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_busy(busy));
    spcm_host u_spcm_host (.i_clk(i_clk), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
        .i_pready(pready), .i_pslverr(pslverr));
    task automatic finish_test;
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] arg(input int p, input int en, input int va, input int s);
        return 32'(p) | (32'(en) << F_ENC) | (32'(va) << F_VAPG) | (32'(s) << F_SLOT);
    endfunction : arg
    // Expected reload tag for a page whose contents are still zero
    function automatic logic [15:0] tg(input int p, input int en, input int v);
        logic [15:0] m;
        m = {8'(v), 2'b00, 2'(en), 4'(p)};
        return {m[10:0], m[15:11]} ^ 16'hA5C3;
    endfunction : tg
    task automatic op(input logic [3:0] c, input logic [31:0] a, input logic [15:0] t,
        input logic [2:0] s);
        logic [31:0] r;
        u_spcm_host.xfer(1'b1, A_ARG, a, q, e);
        u_spcm_host.xfer(1'b1, A_TAGI, {16'h0, t}, q, e);
        u_spcm_host.xfer(1'b1, A_CMD, {28'h0, c}, q, e);
        r = 32'h8;
        while (r[3] !== 1'b0) u_spcm_host.xfer(1'b0, A_STAT, 32'h0, r, e);
        chk({29'h0, r[2:0]}, {29'h0, s});
    endtask : op
    task automatic pg(input int p, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        u_spcm_host.xfer(1'b1, A_ARG, arg(p, 0, 0, 0), q, e);
        u_spcm_host.xfer(1'b0, A_PAGE, 32'h0, r, e);
        chk(r & m, x);
    endtask : pg
    task automatic evict_flow(input int s, input int v);
        op(OP_BLOCK, arg(3, 1, 0, 0), 16'h0, S_OK);
        op(OP_TRACK, arg(1, 1, 0, 0), 16'h0, S_OK);
        op(OP_IPI, arg(3, 1, 0, 0), 16'h0, S_OK);
        op(OP_EVICT, arg(3, 1, 2, s), 16'h0, S_OK);
        u_spcm_host.xfer(1'b0, A_TAGO, 32'h0, q, e);
        chk(q, {16'h0, tg(3, 1, v)});
        pg(3, 32'h00FF0001, 32'(v) << 16);
    endtask : evict_flow
    task automatic t_reset;
        u_spcm_host.xfer(1'b0, A_STAT, 32'h0, q, e);
        chk(q, 32'h0);
        u_spcm_host.xfer(1'b0, A_CFG, 32'h0, q, e);
        chk(q, 32'h0);
        pg(0, 32'hFFFFFFFF, 32'h0);
        u_spcm_host.xfer(1'b0, A_EVT, 32'h0, q, e);
        chk(q, 32'h0);
        u_spcm_host.xfer(1'b0, 8'h40, 32'h0, q, e);
        chk({q[30:0], e}, 32'h1);
    endtask : t_reset
    task automatic t_build;
        op(OP_AUG, arg(5, 1, 0, 0), 16'h0, S_NOSUP);
        pg(5, M, 32'h0);
        op(OP_ADDCTL, arg(1, 1, 0, 0), 16'h0, S_OK);
        op(OP_ADDVA, arg(2, 0, 0, 0), 16'h0, S_OK);
        op(OP_ADDREG, arg(3, 1, 0, 0), 16'h0, S_OK);
        pg(3, 32'h367, 32'h101);
        pg(2, 32'h61, 32'h41);
    endtask : t_build
    task automatic t_evict;
        op(OP_EVICT, arg(1, 1, 2, 1), 16'h0, S_FAIL);
        op(OP_EVICT, arg(2, 0, 2, 3), 16'h0, S_FAIL);
        op(OP_EVICT, arg(3, 1, 2, 1), 16'h0, S_FAIL);
        op(OP_BLOCK, arg(3, 1, 0, 0), 16'h0, S_OK);
        pg(3, 32'h3, 32'h3);
        op(OP_ACCESS, arg(3, 1, 0, 0), 16'h0, S_PF);
        op(OP_EVICT, arg(3, 1, 2, 1), 16'h0, S_FAIL);
        evict_flow(1, 1);
    endtask : t_evict
    task automatic t_reload;
        op(OP_LDU, arg(3, 1, 2, 1), tg(3, 1, 1) ^ 16'h1, S_FAIL);
        pg(3, 32'h1, 32'h0);
        op(OP_LDU, arg(3, 1, 2, 1), tg(3, 1, 1), S_OK);
        pg(3, M, 32'h1);
        evict_flow(2, 2);
        op(OP_LDB, arg(3, 1, 2, 1), tg(3, 1, 1), S_FAIL);
        op(OP_LDB, arg(3, 2, 2, 2), tg(3, 2, 2), S_FAIL);
        op(OP_LDB, arg(3, 1, 2, 2), tg(3, 1, 2), S_OK);
        pg(3, M, 32'h3);
    endtask : t_reload
    task automatic t_dynamic;
        u_spcm_host.xfer(1'b1, A_CFG, 32'h1, q, e);
        op(OP_AUG, arg(3, 1, 0, 0), 16'h0, S_FAIL);
        op(OP_AUG, arg(5, 1, 0, 0), 16'h0, S_OK);
        pg(5, M, 32'h5);
        op(OP_ACCESS, arg(5, 1, 0, 0), 16'h0, S_PF);
        op(OP_ACCEPT, arg(5, 1, 0, 0), 16'h0, S_OK);
        pg(5, M, 32'h1);
        op(OP_ACCESS, arg(5, 1, 0, 0), 16'h0, S_OK);
        pg(5, 32'h9, 32'h9);
        op(4'hF, 32'h0, 16'h0, S_BADOP);
    endtask : t_dynamic
    // Reset in mid-run must clear the enable, the op counter and the page table
    task automatic t_rerun;
        @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset;
        pg(5, 32'hFFFFFFFF, 32'h0);
    endtask : t_rerun
    initial begin
        #200000;
        errors++;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset;
        t_build;
        t_evict;
        t_reload;
        t_dynamic;
        t_rerun;
        finish_test;
    end
endmodule : testbench
